// File: bench/dfac_master.sv
// serial master model issuing one register request at a time
`timescale 1ns/100ps
`default_nettype none
module dfac_master
    import dfac_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resp_valid_i,
    input wire logic [7:0] resp_err_i,
    input wire logic [15:0] resp_rdata_i,
    output logic req_valid_o,
    output dfac_pkg::dfac_access_type req_kind_o,
    output logic [15:0] req_addr_o,
    output logic [15:0] req_wdata_o
);
    initial begin
        req_valid_o = 1'b0;
        req_kind_o = DFAC_ACC_READ;
        req_addr_o = 16'hFFFF;
        req_wdata_o = 16'hFFFF;
    end
    // commit data is whatever the caller gives; callers send zero except to test refusal
    task automatic xfer(input dfac_access_type k, input logic [15:0] a, input logic [15:0] d,
                        output logic [7:0] e, output logic [15:0] r);
        @(posedge sys_clk_i) #1;
        req_valid_o = 1'b1;
        req_kind_o = k;
        req_addr_o = a;
        req_wdata_o = d;
        @(posedge sys_clk_i) #1;
        req_valid_o = 1'b0;
        // released address and data lines show the inverse so stale values cannot pass
        req_addr_o = ~a;
        req_wdata_o = ~d;
        e = resp_valid_i ? resp_err_i : 8'hEE;
        r = resp_rdata_i;
    endtask
endmodule // dfac_master
`default_nettype wire

// File: bench/dfac_regs_bench.sv
// self-checking bench for the fault, alarm and commit register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, g, x); end end
module dfac_regs_bench;
    import dfac_pkg::*;
    int fails = 0;
    int num_checks = 0;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, main_uv = 1'b0, commit_req = 1'b0;
    logic flt_v = 1'b0, nv_done = 1'b0, nv_int = 1'b0;
    logic [15:0] flt_c = 16'h0000, alarm = 16'h0000;
    logic req_v, resp_v, nv_w, nv_b, mism;
    dfac_access_type req_k;
    logic [15:0] req_a, req_d, resp_r, param_a, ref_a, nv_d, r;
    logic [7:0] resp_e, e;
    always #10 sys_clk_i = ~sys_clk_i;
    dfac_master m_u (.sys_clk_i(sys_clk_i), .resp_valid_i(resp_v), .resp_err_i(resp_e),
        .resp_rdata_i(resp_r), .req_valid_o(req_v), .req_kind_o(req_k), .req_addr_o(req_a),
        .req_wdata_o(req_d));
    dfac_regs dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_v),
        .req_kind_i(req_k), .req_addr_i(req_a), .req_wdata_i(req_d), .main_uv_i(main_uv),
        .commit_required_i(commit_req), .fault_valid_i(flt_v), .fault_code_i(flt_c),
        .alarm_code_i(alarm), .nv_done_i(nv_done), .nv_interrupted_i(nv_int),
        .resp_valid_o(resp_v), .resp_err_o(resp_e), .resp_rdata_o(resp_r),
        .param_active_o(param_a), .ref_active_o(ref_a), .nv_write_o(nv_w),
        .nv_data_o(nv_d), .nv_busy_o(nv_b), .mismatch_fault_o(mism));
    task automatic tick;
        @(posedge sys_clk_i) #1;
    endtask
    task automatic rd(input logic [15:0] a);
        m_u.xfer(DFAC_ACC_READ, a, 16'h0000, e, r);
    endtask
    task automatic wp(input logic [15:0] a, input logic [15:0] d);
        m_u.xfer(DFAC_ACC_WRITE_PARAM, a, d, e, r);
    endtask
    task automatic do_reset(input logic intr);
        rst_i = 1'b1;
        nv_int = intr;
        repeat (5) @(posedge sys_clk_i);
        #1 rst_i = 1'b0;
        tick();
        nv_int = 1'b0;
    endtask
    task automatic t_alarm;
        logic [15:0] codes [3] = '{16'h0001, 16'h0007, 16'h0008};
        foreach (codes[i]) begin
            alarm = codes[i];
            rd(16'h007F);
            `CHK(r, codes[i])
        end
        wp(16'h007F, 16'h0000);
        `CHK(e, 8'h22)
        $display("alarm test done");
    endtask
    task automatic t_commit;
        commit_req = 1'b1;
        m_u.xfer(DFAC_ACC_WRITE_REF, 16'h0002, 16'hA5A5, e, r);
        `CHK({e, ref_a}, {8'h00, 16'hA5A5})
        wp(16'h0100, 16'h1234);
        `CHK(param_a, 16'h0000)
        rd(16'h0900);
        `CHK(e, 8'h02)
        rd(16'h0910);
        `CHK(e, 8'h02)
        wp(16'h0910, 16'h0000);
        `CHK({e, param_a, nv_b}, {8'h00, 16'h1234, 1'b0})
        wp(16'h0101, 16'h5678);
        wp(16'h0900, 16'h0001);
        `CHK({e, param_a}, {8'h21, 16'h1234})
        wp(16'h0900, 16'h0000);
        `CHK({e, param_a}, {8'h00, 16'h5678})
        tick();
        `CHK({nv_w, nv_d, nv_b}, {1'b1, 16'h5678, 1'b1})
        wp(16'h0102, 16'h1111);
        `CHK({e, param_a}, {8'h22, 16'h5678})
        // storage finishes before any power loss is simulated
        nv_done = 1'b1;
        tick();
        nv_done = 1'b0;
        tick();
        `CHK(nv_b, 1'b0)
        $display("commit test done");
    endtask
    task automatic t_uv;
        commit_req = 1'b0;
        wp(16'h0100, 16'hBEEF);
        `CHK(param_a, 16'hBEEF)
        main_uv = 1'b1;
        repeat (8) tick();
        wp(16'h0100, 16'h4321);
        `CHK({e, param_a}, {8'h23, 16'hBEEF})
        // one storage commit only in the whole run, to spare the endurance
        wp(16'h0900, 16'h0000);
        `CHK({e, nv_b}, {8'h23, 1'b0})
        m_u.xfer(DFAC_ACC_WRITE_REF, 16'h0002, 16'h0F0F, e, r);
        `CHK({e, ref_a}, {8'h23, 16'hA5A5})
        main_uv = 1'b0;
        repeat (8) tick();
        $display("undervoltage test done");
    endtask
    task automatic t_hist;
        logic [15:0] seq [6] = '{16'h0005, 16'h0002, 16'h0007, 16'h0003, 16'h0083, 16'h0105};
        logic [15:0] expv [4] = '{16'h0105, 16'h0083, 16'h0007, 16'h0005};
        foreach (seq[i]) begin
            flt_v = 1'b1;
            flt_c = seq[i];
            tick();
            flt_v = 1'b0;
            tick();
        end
        foreach (expv[i]) begin
            rd(16'h0080 + 16'(i));
            `CHK(r, expv[i])
        end
        rd(16'h0084);
        `CHK(e, 8'h02)
        $display("history test done");
    endtask
    task automatic t_mism;
        do_reset(1'b1);
        repeat (2) tick();
        `CHK(mism, 1'b1)
        rd(16'h0080);
        `CHK(r, 16'h0087)
        $display("mismatch test done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        do_reset(1'b0);
        t_alarm();
        t_commit();
        t_uv();
        t_hist();
        t_mism();
        close_out();
    end
    // tests need well under a thousand cycles
    initial begin
        #400000;
        fails++;
        close_out();
    end
endmodule // dfac_regs_bench
`default_nettype wire

// File: bench/dfac_regs_sva.sv
// concurrent checks on the fault, alarm and commit register block
`timescale 1ns/100ps
`default_nettype none
module dfac_regs_sva
    import dfac_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire dfac_pkg::dfac_access_type req_kind_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [15:0] req_wdata_i,
    input wire logic main_uv_i,
    input wire logic [15:0] alarm_code_i,
    input wire logic resp_valid_o,
    input wire logic [7:0] resp_err_o,
    input wire logic [15:0] resp_rdata_o,
    input wire logic [15:0] ref_active_o,
    input wire logic nv_write_o,
    input wire logic nv_busy_o,
    input wire logic mismatch_fault_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    property p_answer; req_valid_i |=> resp_valid_o; endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_rdwo;
        req_valid_i && req_kind_i == DFAC_ACC_READ
            && (req_addr_i == 16'h0900 || req_addr_i == 16'h0910) |=> resp_err_o == 8'h02;
    endproperty
    a_rdwo: assert property (p_rdwo) else $error("commit read not refused");
    property p_uv;
        main_uv_i[*8] ##0 (req_valid_i && req_kind_i != DFAC_ACC_READ) |=> resp_err_o == 8'h23;
    endproperty
    a_uv: assert property (p_uv) else $error("write in undervoltage not refused");
    property p_nouv; main_uv_i[*8] |-> !nv_write_o; endproperty
    a_nouv: assert property (p_nouv) else $error("storage write in undervoltage");
    property p_nvgo;
        (!main_uv_i)[*6] ##0 (req_valid_i && req_kind_i == DFAC_ACC_WRITE_PARAM
            && req_addr_i == 16'h0900) ##1 resp_err_o == 8'h00 |=> nv_write_o && nv_busy_o;
    endproperty
    a_nvgo: assert property (p_nvgo) else $error("storage write not started");
    property p_ram;
        req_valid_i && req_kind_i == DFAC_ACC_WRITE_PARAM && req_addr_i == 16'h0910
            |=> ##1 !nv_write_o;
    endproperty
    a_ram: assert property (p_ram) else $error("ram commit wrote storage");
    property p_ref;
        req_valid_i && req_kind_i == DFAC_ACC_WRITE_REF ##1 resp_err_o == 8'h00
            |-> ref_active_o == $past(req_wdata_i);
    endproperty
    a_ref: assert property (p_ref) else $error("reference not applied");
    property p_alarm;
        req_valid_i && req_kind_i == DFAC_ACC_READ && req_addr_i == 16'h007F && !$past(rst_i)
            |=> resp_rdata_o == $past(alarm_code_i, 2);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm read wrong");
    property p_sticky; mismatch_fault_o |=> mismatch_fault_o; endproperty
    a_sticky: assert property (p_sticky) else $error("mismatch flag dropped");
    c_nv: cover property (nv_write_o);
    c_mism: cover property (mismatch_fault_o);
    c_uv: cover property (resp_valid_o && resp_err_o == 8'h23);
endmodule // dfac_regs_sva
bind dfac_regs dfac_regs_sva chk_u (.sys_clk_i, .rst_i, .req_valid_i, .req_kind_i,
    .req_addr_i, .req_wdata_i, .main_uv_i, .alarm_code_i, .resp_valid_o, .resp_err_o,
    .resp_rdata_o, .ref_active_o, .nv_write_o, .nv_busy_o, .mismatch_fault_o);
`default_nettype wire

// File: rtl/dfac_fault_hist.sv
// fault history shift store, newest entry at index 0
`timescale 1ns/100ps
`default_nettype none
`include "dfac_cfg.svh"
module dfac_fault_hist #(
    parameter int DEPTH = `DFAC_HIST_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic rec_valid_i,
    input wire logic [15:0] rec_code_i,
    input wire logic [$clog2(DEPTH)-1:0] rd_index_i,
    output logic [15:0] rd_code_o
);
    logic [15:0] entry_reg [DEPTH];
    logic [15:0] entry_next [DEPTH];
    logic keep;

    always_comb begin
        // undervoltage faults never enter the history
        keep = rec_valid_i && (rec_code_i != `DFAC_FLT_MAIN_UV)
            && (rec_code_i != `DFAC_FLT_CTRL_UV);
        for (int i = 0; i < DEPTH; i++) begin
            entry_next[i] = entry_reg[i];
        end
        if (keep) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                entry_next[i] = entry_reg[i-1];
            end
            entry_next[0] = rec_code_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                entry_reg[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                entry_reg[i] <= entry_next[i];
            end
        end
    end

    assign rd_code_o = entry_reg[rd_index_i];
endmodule // dfac_fault_hist
`default_nettype wire

// File: rtl/dfac_regs.sv
// drive register block: fault history, active alarm and commit registers
// Operation
// - fault history readable as 16-bit codes
// - undervoltage faults 0002H/0003H never recorded
// - power-stage faults in low code range
// - control-board faults from 0083H to 0099H
// - option card faults 0101H to 0105H
// - active alarm code readable at ACTIVE_ALARM_CODE
// - alarm codes have their own encoding
// - commit step depends on requirement setting
// - COMMIT_NONVOLATILE commit stores nonvolatile and activates
// - COMMIT_RAM_ONLY commit activates in RAM only
// - commit registers write-only, read gives 02H
// - reference writes take effect immediately
// - no nonvolatile write during undervoltage
// - interrupted commit flags mismatch at power-up
// - writes during main undervoltage rejected 23H
`timescale 1ns/100ps
`default_nettype none
`include "dfac_cfg.svh"
module dfac_regs #(
    parameter int HIST_DEPTH = `DFAC_HIST_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire dfac_pkg::dfac_access_type req_kind_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [15:0] req_wdata_i,
    input wire logic main_uv_i,
    input wire logic commit_required_i,
    input wire logic fault_valid_i,
    input wire logic [15:0] fault_code_i,
    input wire logic [15:0] alarm_code_i,
    input wire logic nv_done_i,
    input wire logic nv_interrupted_i,
    output logic resp_valid_o,
    output logic [7:0] resp_err_o,
    output logic [15:0] resp_rdata_o,
    output logic [15:0] param_active_o,
    output logic [15:0] ref_active_o,
    output logic nv_write_o,
    output logic [15:0] nv_data_o,
    output logic nv_busy_o,
    output logic mismatch_fault_o
);
    import dfac_pkg::*;

    localparam int IW = $clog2(HIST_DEPTH);

    logic uv_sync;
    logic [15:0] hist_code;
    logic [IW-1:0] hist_index;
    logic [15:0] rec_code;
    logic rec_valid;

    // answer and parameter group
    logic resp_valid_reg;
    logic resp_valid_next;
    logic [7:0] resp_err_reg;
    logic [7:0] resp_err_next;
    logic [15:0] resp_rdata_reg;
    logic [15:0] resp_rdata_next;
    logic [15:0] pending_reg;
    logic [15:0] pending_next;
    logic [15:0] active_reg;
    logic [15:0] active_next;
    logic [15:0] ref_reg;
    logic [15:0] ref_next;
    logic [15:0] alarm_reg;
    logic [15:0] alarm_next;
    logic nv_start;

    // storage commit group
    logic nv_write_reg;
    logic nv_write_next;
    logic [15:0] nv_data_reg;
    logic [15:0] nv_data_next;
    logic nv_in_flight_reg;
    logic nv_in_flight_next;
    dfac_nv_state_type nv_state_reg;
    dfac_nv_state_type nv_state_next;

    // power-up mismatch group
    logic mismatch_reg;
    logic mismatch_next;
    logic armed_reg;
    logic armed_next;

    function automatic logic is_commit(input logic [15:0] addr);
        is_commit = (addr == `DFAC_ADDR_COMMIT_NV) || (addr == `DFAC_ADDR_COMMIT_RAM);
    endfunction

    function automatic logic is_hist(input logic [15:0] addr);
        is_hist = (addr >= `DFAC_ADDR_HIST_BASE)
            && (addr < `DFAC_ADDR_HIST_BASE + 16'(HIST_DEPTH));
    endfunction

    dfac_sync u_uv_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .async_i(main_uv_i),
        .sync_o(uv_sync)
    );

    // a mismatch fault raised at power-up is logged like any other fault
    assign rec_valid = fault_valid_i || (mismatch_next && !mismatch_reg);
    assign rec_code = (mismatch_next && !mismatch_reg) ? `DFAC_FLT_STORED_MISMATCH
        : fault_code_i;
    assign hist_index = IW'(req_addr_i - `DFAC_ADDR_HIST_BASE);

    dfac_fault_hist #(
        .DEPTH(HIST_DEPTH)
    ) u_hist (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .rec_valid_i(rec_valid),
        .rec_code_i(rec_code),
        .rd_index_i(hist_index),
        .rd_code_o(hist_code)
    );

    // request decode and answers
    always_comb begin
        resp_valid_next = 1'b0;
        resp_err_next = `DFAC_ERR_NONE;
        resp_rdata_next = 16'h0000;
        pending_next = pending_reg;
        active_next = active_reg;
        ref_next = ref_reg;
        alarm_next = alarm_code_i;
        nv_start = 1'b0;
        if (req_valid_i) begin
            resp_valid_next = 1'b1;
            unique case (req_kind_i)
                DFAC_ACC_READ: begin
                    if (req_addr_i == `DFAC_ADDR_ALARM) begin
                        resp_rdata_next = alarm_reg;
                    end else if (is_hist(req_addr_i)) begin
                        resp_rdata_next = hist_code;
                    end else begin
                        // commit registers fall here as well
                        resp_err_next = `DFAC_ERR_ADDR;
                    end
                end
                DFAC_ACC_WRITE_REF: begin
                    if (uv_sync) begin
                        resp_err_next = `DFAC_ERR_UV;
                    end else begin
                        ref_next = req_wdata_i;
                    end
                end
                DFAC_ACC_WRITE_PARAM: begin
                    if (uv_sync) begin
                        resp_err_next = `DFAC_ERR_UV;
                    end else if (nv_state_reg != DFAC_ST_IDLE) begin
                        // busy committing, write refused
                        resp_err_next = `DFAC_ERR_MODE;
                    end else if (is_commit(req_addr_i)) begin
                        if (req_wdata_i != `DFAC_COMMIT_VALUE) begin
                            resp_err_next = `DFAC_ERR_DATA;
                        end else begin
                            active_next = pending_reg;
                            // storage takes the same word that goes live
                            nv_start = (req_addr_i == `DFAC_ADDR_COMMIT_NV);
                        end
                    end else if (req_addr_i == `DFAC_ADDR_ALARM || is_hist(req_addr_i)) begin
                        resp_err_next = `DFAC_ERR_MODE;
                    end else begin
                        pending_next = req_wdata_i;
                        if (!commit_required_i) begin
                            active_next = req_wdata_i;
                        end
                    end
                end
                default: begin
                    resp_err_next = `DFAC_ERR_ADDR;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            resp_valid_reg <= 1'b0;
            resp_err_reg <= `DFAC_ERR_NONE;
            resp_rdata_reg <= 16'h0000;
            pending_reg <= 16'h0000;
            active_reg <= 16'h0000;
            ref_reg <= 16'h0000;
            alarm_reg <= `DFAC_ALM_NONE;
        end else begin
            resp_valid_reg <= resp_valid_next;
            resp_err_reg <= resp_err_next;
            resp_rdata_reg <= resp_rdata_next;
            pending_reg <= pending_next;
            active_reg <= active_next;
            ref_reg <= ref_next;
            alarm_reg <= alarm_next;
        end
    end

    // storage commit sequencer; a start is only accepted while idle
    always_comb begin
        nv_data_next = nv_data_reg;
        nv_state_next = nv_state_reg;
        nv_write_next = 1'b0;
        unique case (nv_state_reg)
            DFAC_ST_IDLE: begin
                if (nv_start) begin
                    nv_data_next = pending_reg;
                    nv_state_next = DFAC_ST_NV_WRITE;
                end
            end
            DFAC_ST_NV_WRITE: begin
                if (uv_sync) begin
                    nv_state_next = DFAC_ST_IDLE;
                end else begin
                    nv_write_next = 1'b1;
                    nv_state_next = DFAC_ST_NV_WAIT;
                end
            end
            DFAC_ST_NV_WAIT: begin
                // hold until storage reports completion or supply drop
                if (nv_done_i || uv_sync) begin
                    nv_state_next = DFAC_ST_IDLE;
                end
            end
        endcase
        // busy covers the wait for the storage acknowledge only
        nv_in_flight_next = (nv_state_next == DFAC_ST_NV_WAIT);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nv_write_reg <= 1'b0;
            nv_data_reg <= 16'h0000;
            nv_state_reg <= DFAC_ST_IDLE;
            nv_in_flight_reg <= 1'b0;
        end else begin
            nv_write_reg <= nv_write_next;
            nv_data_reg <= nv_data_next;
            nv_state_reg <= nv_state_next;
            nv_in_flight_reg <= nv_in_flight_next;
        end
    end

    // interrupted commit flag, caught once after reset release
    always_comb begin
        armed_next = 1'b1;
        mismatch_next = mismatch_reg;
        if (!armed_reg && nv_interrupted_i) begin
            mismatch_next = 1'b1;
        end
    end

    // sticky until reset: the stored set stays suspect until reloaded
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mismatch_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            mismatch_reg <= mismatch_next;
            armed_reg <= armed_next;
        end
    end

    assign resp_valid_o = resp_valid_reg;
    assign resp_err_o = resp_err_reg;
    assign resp_rdata_o = resp_rdata_reg;
    assign param_active_o = active_reg;
    assign ref_active_o = ref_reg;
    assign nv_write_o = nv_write_reg;
    assign nv_data_o = nv_data_reg;
    assign nv_busy_o = nv_in_flight_reg;
    assign mismatch_fault_o = mismatch_reg;
endmodule // dfac_regs
`default_nettype wire

// File: rtl/dfac_sync.sv
// three-stage synchroniser, change accepted when the last two stages agree
`timescale 1ns/100ps
`default_nettype none
module dfac_sync (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic out_reg;
    logic out_next;

    always_comb begin
        stage_next = {stage_reg[1:0], async_i};
        out_next = (stage_reg[2] == stage_reg[1]) ? stage_reg[2] : out_reg;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage_reg <= 3'h0;
            out_reg <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            out_reg <= out_next;
        end
    end

    assign sync_o = out_reg;
endmodule // dfac_sync
`default_nettype wire

// File: shared/dfac_cfg.svh
// constants for the drive fault, alarm and commit register block
`ifndef DFAC_CFG_SVH
`define DFAC_CFG_SVH
`define DFAC_ADDR_ALARM 16'h007F
`define DFAC_ADDR_COMMIT_NV 16'h0900
`define DFAC_ADDR_COMMIT_RAM 16'h0910
`define DFAC_ADDR_HIST_BASE 16'h0080
`define DFAC_HIST_DEPTH 4
`define DFAC_COMMIT_VALUE 16'h0000
`define DFAC_ERR_NONE 8'h00
`define DFAC_ERR_ADDR 8'h02
`define DFAC_ERR_DATA 8'h21
`define DFAC_ERR_MODE 8'h22
`define DFAC_ERR_UV 8'h23
`define DFAC_FLT_MAIN_UV 16'h0002
`define DFAC_FLT_CTRL_UV 16'h0003
`define DFAC_FLT_SOFT_CHARGE 16'h0004
`define DFAC_FLT_OUT_SHORT 16'h0005
`define DFAC_FLT_OVERCURRENT 16'h0007
`define DFAC_FLT_CONVERTER 16'h0083
`define DFAC_FLT_CAPACITY 16'h0099
`define DFAC_FLT_OPT_FIRST 16'h0101
`define DFAC_FLT_OPT_FLASH 16'h0105
`define DFAC_FLT_STORED_MISMATCH 16'h0087
`define DFAC_ALM_UNDERVOLTAGE 16'h0001
`define DFAC_ALM_RUN_CMD 16'h0007
`define DFAC_ALM_OUT_BLOCKED 16'h0008
`define DFAC_ALM_NONE 16'h0000
`endif

// File: shared/dfac_pkg.sv
// types for the drive fault, alarm and commit register block
package dfac_pkg;
    typedef enum logic [1:0] {
        DFAC_ACC_READ,
        DFAC_ACC_WRITE_PARAM,
        DFAC_ACC_WRITE_REF
    } dfac_access_type;
    typedef enum {
        DFAC_ST_IDLE,
        DFAC_ST_NV_WRITE,
        DFAC_ST_NV_WAIT
    } dfac_nv_state_type;
endpackage
